/* pkg/tcap_pkg.sv */
// Shared constants for the 16-bit timer counter with input capture
package tcap_pkg;

   // Byte locations on the 8-bit register port
   localparam logic [3:0] TCAP_ADDR_CTRL_A    = 4'h0; // Mode low bits
   localparam logic [3:0] TCAP_ADDR_CTRL_B    = 4'h1; // Clock, mode, capture
   localparam logic [3:0] TCAP_ADDR_CNT_LO    = 4'h2; // Count low byte
   localparam logic [3:0] TCAP_ADDR_CNT_HI    = 4'h3; // Count high (latch)
   localparam logic [3:0] TCAP_ADDR_CAP_LO    = 4'h4; // Capture low byte
   localparam logic [3:0] TCAP_ADDR_CAP_HI    = 4'h5; // Capture high (latch)
   localparam logic [3:0] TCAP_ADDR_IRQ_EN    = 4'h6; // Interrupt enables
   localparam logic [3:0] TCAP_ADDR_FLAGS     = 4'h7; // Event flags, W1C
   localparam logic [3:0] TCAP_ADDR_CMP_CTRL  = 4'h8; // Comparator control

   // Field positions
   localparam int TCAP_CTRLA_WGM_LSB  = 0; // waveform_mode_select[1:0]
   localparam int TCAP_CTRLB_CS_LSB   = 0; // clock_source_select[2:0]
   localparam int TCAP_CTRLB_WGM_LSB  = 3; // waveform_mode_select[3:2]
   localparam int TCAP_CTRLB_EDGE_BIT = 6; // 1: rising edge captures
   localparam int TCAP_CTRLB_FILT_BIT = 7; // noise_filter_enable
   localparam int TCAP_OVF_BIT        = 2; // Overflow flag / enable
   localparam int TCAP_CAP_BIT        = 5; // Capture flag / enable
   localparam int TCAP_CMP_SEL_BIT    = 2; // comparator_capture_select

   // Reset values
   localparam logic [7:0]  TCAP_RST_BYTE = 8'h00;
   localparam logic [15:0] TCAP_RST_WORD = 16'h0000;

   // Clock source select codes
   localparam logic [2:0] TCAP_CS_STOP   = 3'h0; // No tick, counter halts
   localparam logic [2:0] TCAP_CS_DIV1   = 3'h1;
   localparam logic [2:0] TCAP_CS_DIV8   = 3'h2;
   localparam logic [2:0] TCAP_CS_DIV64  = 3'h3;
   localparam logic [2:0] TCAP_CS_DIV256 = 3'h4;
   localparam logic [2:0] TCAP_CS_DIV1K  = 3'h5;
   localparam logic [2:0] TCAP_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] TCAP_CS_EXT_RISE = 3'h7;

   // Prescaler tap masks: a tick fires when the masked bits are all ones
   localparam logic [9:0] TCAP_PRE_MASK8   = 10'h007;
   localparam logic [9:0] TCAP_PRE_MASK64  = 10'h03F;
   localparam logic [9:0] TCAP_PRE_MASK256 = 10'h0FF;
   localparam logic [9:0] TCAP_PRE_MASK1K  = 10'h3FF;

   // Fixed top values
   localparam logic [15:0] TCAP_TOP_8BIT  = 16'h00FF;
   localparam logic [15:0] TCAP_TOP_9BIT  = 16'h01FF;
   localparam logic [15:0] TCAP_TOP_10BIT = 16'h03FF;
   localparam logic [15:0] TCAP_MAX       = 16'hFFFF;

   // Mode classes, one bit per waveform mode number
   localparam logic [15:0] TCAP_WGM_DUAL    = 16'h0F0E; // Up-down modes
   localparam logic [15:0] TCAP_WGM_TOP8    = 16'h0022;
   localparam logic [15:0] TCAP_WGM_TOP9    = 16'h0044;
   localparam logic [15:0] TCAP_WGM_TOP10   = 16'h0088;
   localparam logic [15:0] TCAP_WGM_TOP_CAP = 16'h5500; // Capture is top
   localparam logic [15:0] TCAP_WGM_TOP_CPA = 16'h8A10; // Compare A is top
   localparam logic [15:0] TCAP_WGM_OVF_MAX = 16'h1010; // Clear-on-match

   // Count direction
   typedef enum logic {TCAP_UP, TCAP_DOWN} tcap_dir_t;

endpackage : tcap_pkg

/* src/tcap_edge_sampler.sv */
`timescale 1ns/1ps
// Synchroniser, optional four-sample filter and edge detector
module tcap_edge_sampler
   import tcap_pkg::*;
(
   input  wire logic clk_i,      // System clock
   input  wire logic arst_n_i,   // Asynchronous reset, active low
   input  wire logic pin_i,      // Asynchronous level to watch
   input  wire logic filt_en_i,  // Four-sample filter in the path
   input  wire logic enable_i,   // Edge outputs allowed
   output logic      rise_o,     // One-cycle rising edge pulse
   output logic      fall_o      // One-cycle falling edge pulse
);

   logic       sync1_r;  // First stage, read only by sync2_r
   logic       sync2_r;  // Second stage, safe to use
   logic [2:0] hist_r;   // Older samples of sync2_r
   logic       filt_r;   // Filtered level
   logic       prev_r;   // Level seen one cycle ago
   logic       level;    // Level fed to the edge detector

   // Two flops take the pin into the clock domain
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
      end
   end

   // Filter moves only on four equal samples; runs on the raw clock
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hist_r <= 3'h0;
         filt_r <= 1'b0;
      end else begin
         hist_r <= {hist_r[1:0], sync2_r};
         if (hist_r == {3{sync2_r}}) begin
            filt_r <= sync2_r;
         end
      end
   end

   // Filter adds four cycles when chosen
   assign level = filt_en_i ? filt_r : sync2_r;

   // Previous level for the edge detector
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= level;
      end
   end

   // Edges only while enabled
   assign rise_o = enable_i & level & ~prev_r;
   assign fall_o = enable_i & ~level & prev_r;

endmodule : tcap_edge_sampler

/* src/tcap_timer.sv */
`timescale 1ns/1ps
// What this block does
// - Count visible as low and high bytes
// - Count low read copies high to latch
// - Count low write loads high from latch
// - Select zero stops count, access stays
// - CPU count write beats tick update
// - Each tick clears, increments or decrements
// - Flag count at zero and at max
// - Four-bit mode split over two registers
// - Overflow flag set per mode, irq
// - Trigger is pin or comparator output
// - Edge copies count, sets flag together
// - Flag irq, cleared by ack or write-one
// - Capture low read latches high byte
// - Capture writable only as top value
// - Source change may capture; clear flag
// - Inputs synchronised like external count pin
// - Filter needs four equal raw samples
// - Filter adds four cycles of delay
// - Capture inputs off in capture-top modes
// - Software pin drive also captures
module tcap_timer
   import tcap_pkg::*;
(
   input  wire logic        clk_i,         // System clock, 200 MHz
   input  wire logic        arst_n_i,      // Asynchronous reset, active low
   input  wire logic [3:0]  bus_addr_i,    // Byte location
   input  wire logic        bus_wr_i,      // Write strobe, one cycle
   input  wire logic        bus_rd_i,      // Read strobe, one cycle
   input  wire logic [7:0]  bus_wdata_i,   // Write data
   output logic      [7:0]  bus_rdata_o,   // Read data, next cycle
   input  wire logic        capture_input_pin_i,  // Capture pin
   input  wire logic        comparator_output_i,  // Comparator result
   input  wire logic        external_count_pin_i, // External tick pin
   input  wire logic [15:0] cmp_a_top_i,   // Top value from compare A
   input  wire logic        cap_irq_ack_i, // Capture irq being served
   input  wire logic        ovf_irq_ack_i, // Overflow irq being served
   output logic             cap_irq_o,     // Capture interrupt request
   output logic             ovf_irq_o,     // Overflow interrupt request
   output logic             at_zero_o,     // Count equals zero
   output logic             at_max_o,      // Count equals mode top
   output logic             timer_tick_o,  // Tick used by the counter
   output logic [15:0]      count_value_o  // Current count
);

   // Software visible state
   logic [7:0]  control_reg_a_r;    // Mode low bits
   logic [7:0]  control_reg_b_r;    // Clock, mode high, capture setup
   logic [7:0]  irq_en_r;           // Interrupt enables
   logic [7:0]  cmp_ctrl_r;         // Comparator control
   logic [7:0]  temp_r;             // Shared high-byte latch
   logic [15:0] count_r;            // count_value
   logic [15:0] capture_r;          // capture_register
   logic        cap_flag_r;         // capture_flag
   logic        ovf_flag_r;         // overflow_flag
   logic [7:0]  rdata_r;            // Registered read data
   tcap_dir_t   dir_r;              // Count direction
   logic [9:0]  presc_r;            // Free-running prescaler

   // Derived control
   logic [3:0]  waveform_mode_select;
   logic [2:0]  clock_source_select;
   logic [15:0] mode_bit;           // One-hot of the mode number
   logic        dual_slope;         // Up-down counting
   logic        cap_is_top;         // Capture register defines top
   logic [15:0] top_value;          // Highest count in this mode
   logic [15:0] count_nxt;          // Count after a tick
   tcap_dir_t   dir_nxt;            // Direction after a tick
   logic        ovf_event;          // Overflow on this tick
   logic        tick;               // Counter tick this cycle
   logic        ext_rise;           // External pin edges
   logic        ext_fall;
   logic        cap_rise;           // Capture trigger edges
   logic        cap_fall;
   logic        cap_event;          // Qualifying capture edge
   logic        trig_src;           // Selected raw trigger
   logic        wr_cnt_lo;          // Decoded bus accesses
   logic        rd_cnt_lo;
   logic        rd_cap_lo;
   logic        wr_hi;
   logic        wr_cap_lo;
   logic        wr_flags;

   // Mode field is spread over both control registers
   assign waveform_mode_select = {
      control_reg_b_r[TCAP_CTRLB_WGM_LSB+1:TCAP_CTRLB_WGM_LSB],
      control_reg_a_r[TCAP_CTRLA_WGM_LSB+1:TCAP_CTRLA_WGM_LSB]
   };
   assign clock_source_select =
      control_reg_b_r[TCAP_CTRLB_CS_LSB+2:TCAP_CTRLB_CS_LSB];
   assign mode_bit   = 16'h0001 << waveform_mode_select;
   assign dual_slope = |(mode_bit & TCAP_WGM_DUAL);
   assign cap_is_top = |(mode_bit & TCAP_WGM_TOP_CAP);

   // Top value chosen by mode; unlisted modes run to the full range
   always_comb begin
      if (|(mode_bit & TCAP_WGM_TOP8)) begin
         top_value = TCAP_TOP_8BIT;
      end else if (|(mode_bit & TCAP_WGM_TOP9)) begin
         top_value = TCAP_TOP_9BIT;
      end else if (|(mode_bit & TCAP_WGM_TOP10)) begin
         top_value = TCAP_TOP_10BIT;
      end else if (cap_is_top) begin
         top_value = capture_r;
      end else if (|(mode_bit & TCAP_WGM_TOP_CPA)) begin
         top_value = cmp_a_top_i;
      end else begin
         top_value = TCAP_MAX;
      end
   end

   // Bus decode; the port is a simple strobe interface
   assign wr_cnt_lo = bus_wr_i && (bus_addr_i == TCAP_ADDR_CNT_LO);
   assign rd_cnt_lo = bus_rd_i && (bus_addr_i == TCAP_ADDR_CNT_LO);
   assign rd_cap_lo = bus_rd_i && (bus_addr_i == TCAP_ADDR_CAP_LO);
   assign wr_cap_lo = bus_wr_i && (bus_addr_i == TCAP_ADDR_CAP_LO)
                      && cap_is_top;
   assign wr_flags  = bus_wr_i && (bus_addr_i == TCAP_ADDR_FLAGS);
   // Both high locations write the shared latch, as for compare regs
   assign wr_hi     = bus_wr_i && ((bus_addr_i == TCAP_ADDR_CNT_HI) ||
                                   (bus_addr_i == TCAP_ADDR_CAP_HI));

   // Prescaler counts every system clock
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         presc_r <= 10'h000;
      end else begin
         presc_r <= presc_r + 10'h001;
      end
   end

   // External count pin sampled with the same logic as capture inputs
   tcap_edge_sampler u_ext_sampler (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     (external_count_pin_i),
      .filt_en_i (1'b0),
      .enable_i  (1'b1),
      .rise_o    (ext_rise),
      .fall_o    (ext_fall)
   );

   // Tick selection; select zero gives no tick at all
   always_comb begin
      case (clock_source_select)
         TCAP_CS_STOP:     tick = 1'b0;
         TCAP_CS_DIV1:     tick = 1'b1;
         TCAP_CS_DIV8:     tick = &(presc_r | ~TCAP_PRE_MASK8);
         TCAP_CS_DIV64:    tick = &(presc_r | ~TCAP_PRE_MASK64);
         TCAP_CS_DIV256:   tick = &(presc_r | ~TCAP_PRE_MASK256);
         TCAP_CS_DIV1K:    tick = &(presc_r | ~TCAP_PRE_MASK1K);
         TCAP_CS_EXT_FALL: tick = ext_fall;
         TCAP_CS_EXT_RISE: tick = ext_rise;
         default:          tick = 1'b0;
      endcase
   end

   // Next count and direction for one tick
   always_comb begin
      count_nxt = count_r;
      dir_nxt   = dir_r;
      if (!dual_slope) begin
         // Single slope: wrap to zero at top, else step up
         dir_nxt = TCAP_UP;
         if (count_r == top_value) begin
            count_nxt = TCAP_RST_WORD;
         end else begin
            count_nxt = count_r + 16'h0001;
         end
      end else begin
         case (dir_r)
            TCAP_UP: begin
               // Turn at top; a count above top also turns down
               if (count_r >= top_value) begin
                  dir_nxt   = TCAP_DOWN;
                  count_nxt = count_r - 16'h0001;
               end else begin
                  count_nxt = count_r + 16'h0001;
               end
            end
            TCAP_DOWN: begin
               if (count_r == TCAP_RST_WORD) begin
                  dir_nxt   = TCAP_UP;
                  count_nxt = count_r + 16'h0001;
               end else begin
                  count_nxt = count_r - 16'h0001;
               end
            end
            default: begin
               dir_nxt   = TCAP_UP;
               count_nxt = count_r;
            end
         endcase
      end
   end

   // Overflow point depends on the mode
   always_comb begin
      if (dual_slope) begin
         ovf_event = tick && (dir_r == TCAP_DOWN) &&
                     (count_r == TCAP_RST_WORD);
      end else if (|(mode_bit & TCAP_WGM_OVF_MAX)) begin
         ovf_event = tick && (count_r == TCAP_MAX);
      end else begin
         ovf_event = tick && (count_r == top_value);
      end
   end

   // Counter; a CPU write wins over any tick in the same cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_r <= TCAP_RST_WORD;
         dir_r   <= TCAP_UP;
      end else if (wr_cnt_lo) begin
         count_r <= {temp_r, bus_wdata_i};
      end else if (tick) begin
         count_r <= count_nxt;
         dir_r   <= dir_nxt;
      end else if (!dual_slope) begin
         dir_r   <= TCAP_UP;
      end
   end

   // Shared high-byte latch; later writes simply reuse its content
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         temp_r <= TCAP_RST_BYTE;
      end else if (rd_cnt_lo) begin
         temp_r <= count_r[15:8];
      end else if (rd_cap_lo) begin
         temp_r <= capture_r[15:8];
      end else if (wr_hi) begin
         temp_r <= bus_wdata_i;
      end
   end

   // Trigger source is muxed before the synchroniser, so a switch
   // of source can itself look like an edge; software clears after
   assign trig_src = cmp_ctrl_r[TCAP_CMP_SEL_BIT] ?
                     comparator_output_i : capture_input_pin_i;

   // Same sampler as the external pin; a port-driven pin change is
   // just another edge here
   tcap_edge_sampler u_cap_sampler (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     (trig_src),
      .filt_en_i (control_reg_b_r[TCAP_CTRLB_FILT_BIT]),
      .enable_i  (!cap_is_top),
      .rise_o    (cap_rise),
      .fall_o    (cap_fall)
   );

   assign cap_event = control_reg_b_r[TCAP_CTRLB_EDGE_BIT] ?
                      cap_rise : cap_fall;

   // Capture register; no capture can occur while it is writable
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         capture_r <= TCAP_RST_WORD;
      end else if (cap_event) begin
         capture_r <= count_r;
      end else if (wr_cap_lo) begin
         capture_r <= {temp_r, bus_wdata_i};
      end
   end

   // Capture flag: set in the capture cycle, set beats clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cap_flag_r <= 1'b0;
      end else if (cap_event) begin
         cap_flag_r <= 1'b1;
      end else if (cap_irq_ack_i ||
                   (wr_flags && bus_wdata_i[TCAP_CAP_BIT])) begin
         cap_flag_r <= 1'b0;
      end
   end

   // Overflow flag: same clearing scheme
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovf_flag_r <= 1'b0;
      end else if (ovf_event) begin
         ovf_flag_r <= 1'b1;
      end else if (ovf_irq_ack_i ||
                   (wr_flags && bus_wdata_i[TCAP_OVF_BIT])) begin
         ovf_flag_r <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         control_reg_a_r <= TCAP_RST_BYTE;
         control_reg_b_r <= TCAP_RST_BYTE;
         irq_en_r        <= TCAP_RST_BYTE;
         cmp_ctrl_r      <= TCAP_RST_BYTE;
      end else if (bus_wr_i) begin
         case (bus_addr_i)
            TCAP_ADDR_CTRL_A:   control_reg_a_r <= bus_wdata_i;
            TCAP_ADDR_CTRL_B:   control_reg_b_r <= bus_wdata_i;
            TCAP_ADDR_IRQ_EN:   irq_en_r        <= bus_wdata_i;
            TCAP_ADDR_CMP_CTRL: cmp_ctrl_r      <= bus_wdata_i;
            default: ;
         endcase
      end
   end

   // Read data, registered; unmapped locations read zero
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= TCAP_RST_BYTE;
      end else if (bus_rd_i) begin
         case (bus_addr_i)
            TCAP_ADDR_CTRL_A:   rdata_r <= control_reg_a_r;
            TCAP_ADDR_CTRL_B:   rdata_r <= control_reg_b_r;
            TCAP_ADDR_CNT_LO:   rdata_r <= count_r[7:0];
            TCAP_ADDR_CNT_HI:   rdata_r <= temp_r;
            TCAP_ADDR_CAP_LO:   rdata_r <= capture_r[7:0];
            TCAP_ADDR_CAP_HI:   rdata_r <= temp_r;
            TCAP_ADDR_IRQ_EN:   rdata_r <= irq_en_r;
            TCAP_ADDR_FLAGS: begin
               rdata_r                <= TCAP_RST_BYTE;
               rdata_r[TCAP_CAP_BIT]  <= cap_flag_r;
               rdata_r[TCAP_OVF_BIT]  <= ovf_flag_r;
            end
            TCAP_ADDR_CMP_CTRL: rdata_r <= cmp_ctrl_r;
            default:            rdata_r <= TCAP_RST_BYTE;
         endcase
      end
   end

   // Outputs
   assign bus_rdata_o   = rdata_r;
   assign cap_irq_o     = cap_flag_r & irq_en_r[TCAP_CAP_BIT];
   assign ovf_irq_o     = ovf_flag_r & irq_en_r[TCAP_OVF_BIT];
   assign at_zero_o     = (count_r == TCAP_RST_WORD);
   assign at_max_o      = (count_r == top_value);
   assign timer_tick_o  = tick;
   assign count_value_o = count_r;

endmodule : tcap_timer

/* verif/tcap_event_src.sv */
`timescale 1ns/1ps
// Far-side event source: capture pin level and comparator result
module tcap_event_src
   import tcap_pkg::*;
(
   output logic pin_o, // Capture pin level
   output logic cmp_o  // Comparator result level
);
   // Called at a falling edge, far from the sampling edge
   task automatic drive(input logic pin, input logic cmp);
      pin_o = pin; // Software drives the pin as a port
      cmp_o = cmp; // Comparator settles on its own
   endtask : drive
   // Both inputs start low
   initial drive(1'b0, 1'b0);
endmodule : tcap_event_src

/* verif/tcap_timer_asserts.sv */
`timescale 1ns/1ps
// Port checks for byte access, count stepping and flag clearing
module tcap_timer_asserts
   import tcap_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic [3:0]  bus_addr_i,
   input wire logic        bus_wr_i,
   input wire logic        bus_rd_i,
   input wire logic [7:0]  bus_wdata_i,
   input wire logic [7:0]  bus_rdata_o,
   input wire logic        capture_input_pin_i,
   input wire logic        comparator_output_i,
   input wire logic        cap_irq_ack_i,
   input wire logic        ovf_irq_ack_i,
   input wire logic        cap_irq_o,
   input wire logic        ovf_irq_o,
   input wire logic        timer_tick_o,
   input wire logic [15:0] count_value_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Decoded count byte accesses
   wire rd_lo = bus_rd_i && bus_addr_i == TCAP_ADDR_CNT_LO;
   wire rd_hi = bus_rd_i && bus_addr_i == TCAP_ADDR_CNT_HI;
   wire wr_lo = bus_wr_i && bus_addr_i == TCAP_ADDR_CNT_LO;
   wire wr_hi = bus_wr_i && bus_addr_i == TCAP_ADDR_CNT_HI;
   sequence s_rd_pair; rd_lo ##1 rd_hi; endsequence
   sequence s_wr_pair; wr_hi ##1 wr_lo; endsequence
   // Eight quiet cycles: no capture can still be in flight
   sequence s_quiet;
      (!bus_wr_i && $stable(capture_input_pin_i)
       && $stable(comparator_output_i)) [*8];
   endsequence
   AST_RD_LO: assert property (
      rd_lo |=> bus_rdata_o == $past(count_value_o[7:0]))
      else $error("count low read gave wrong byte");
   AST_RD_HI: assert property (
      s_rd_pair |=> bus_rdata_o == $past(count_value_o[15:8], 2))
      else $error("count high read missed latched byte");
   AST_WR_PAIR: assert property (
      s_wr_pair |=> count_value_o == {$past(bus_wdata_i, 2),
                                      $past(bus_wdata_i)})
      else $error("count word write not atomic");
   AST_WR_WINS: assert property (
      wr_lo && timer_tick_o |=> count_value_o[7:0] == $past(bus_wdata_i))
      else $error("tick beat count write");
   AST_STOP: assert property (
      !timer_tick_o && !wr_lo |=> $stable(count_value_o))
      else $error("count moved without tick");
   AST_STEP: assert property (
      timer_tick_o && !wr_lo |=> count_value_o == 16'h0000
      || count_value_o == $past(count_value_o) + 16'h0001
      || count_value_o == $past(count_value_o) - 16'h0001)
      else $error("tick step not clear or one");
   AST_OVF_ACK: assert property (
      ovf_irq_ack_i && !timer_tick_o |=> !ovf_irq_o)
      else $error("overflow ack left request");
   AST_CAP_ACK: assert property (
      s_quiet ##0 cap_irq_ack_i |=> !cap_irq_o)
      else $error("capture ack left request");
endmodule : tcap_timer_asserts

bind tcap_timer tcap_timer_asserts u_chk (
   .clk_i, .arst_n_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i,
   .bus_rdata_o, .capture_input_pin_i, .comparator_output_i,
   .cap_irq_ack_i, .ovf_irq_ack_i, .cap_irq_o, .ovf_irq_o, .timer_tick_o,
   .count_value_o
);

/* verif/tcap_timer_test.sv */
`timescale 1ns/1ps
// Self-checking bench: counting, capture, filter and trigger source
module tcap_timer_test
   import tcap_pkg::*;
;
   logic        clk_i, arst_n_i, bus_wr_i, bus_rd_i; // Clock, reset, strobes
   logic [3:0]  bus_addr_i;                          // Byte location
   logic [7:0]  bus_wdata_i, bus_rdata_o;            // Bus data
   logic        cap_pin, cmp_out, cap_ack, ovf_ack;  // Events and acks
   logic        cap_irq, ovf_irq, at_zero, at_max;   // Status
   logic [15:0] count, rd_val;                       // Count, read word
   int          err_count, checks_done, lat_raw, lat_flt;
   tcap_timer i_dut (
      .clk_i, .arst_n_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i,
      .bus_rdata_o, .capture_input_pin_i(cap_pin),
      .comparator_output_i(cmp_out), .external_count_pin_i(1'b0),
      .cmp_a_top_i(16'hFFFF), .cap_irq_ack_i(cap_ack),
      .ovf_irq_ack_i(ovf_ack), .cap_irq_o(cap_irq), .ovf_irq_o(ovf_irq),
      .at_zero_o(at_zero), .at_max_o(at_max), .timer_tick_o(),
      .count_value_o(count));
   tcap_event_src i_src (.pin_o(cap_pin), .cmp_o(cmp_out));
   // 200 MHz clock
   initial begin
      clk_i = 1'b1; // High start: no false falling edge at time zero
      forever #2.5 clk_i = ~clk_i;
   end
   // One bus cycle: set at a falling edge, taken at the next rising one
   task automatic op(input logic w, r, input logic [3:0] a,
                     input logic [7:0] d);
      bus_wr_i = w;
      bus_rd_i = r;
      bus_addr_i = a;
      bus_wdata_i = d;
      @(negedge clk_i);
   endtask : op
   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
   endtask : wr8
   task automatic idle(input int n);
      repeat (n) op(1'b0, 1'b0, 4'h0, 8'h00);
   endtask : idle
   // Low byte first, so the high byte comes from the latch
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      op(1'b0, 1'b1, a, 8'h00);
      v[7:0] = bus_rdata_o;
      op(1'b0, 1'b1, a + 4'h1, 8'h00);
      v[15:8] = bus_rdata_o;
   endtask : rd16
   // High byte into the latch, then the low byte commits the word
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr8(a + 4'h1, v[15:8]);
      wr8(a, v[7:0]);
   endtask : wr16
   task automatic chk(input logic [15:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   // Bounded wait for the capture request; n counts the cycles
   task automatic wait_irq(output int n);
      n = 0;
      while (cap_irq !== 1'b1) begin
         idle(1);
         n++;
         if (n > 40) begin
            err_count++;
            tally_and_finish();
         end
      end
   endtask : wait_irq
   // Write priority over a tick, 8-bit top wrap, overflow acknowledge
   task automatic t_run();
      wr8(TCAP_ADDR_IRQ_EN, 8'h04);
      wr8(TCAP_ADDR_CNT_HI, 8'h55);
      wr8(TCAP_ADDR_CTRL_B, 8'h01);
      wr8(TCAP_ADDR_CNT_LO, 8'hAA); // Lands in a tick cycle
      wr8(TCAP_ADDR_CTRL_B, 8'h00); // Last tick adds one, then stop
      rd16(TCAP_ADDR_CNT_LO, rd_val);
      chk(rd_val, 16'h55AB);
      wr8(TCAP_ADDR_CTRL_A, 8'h01);
      wr8(TCAP_ADDR_CTRL_B, 8'h08); // Mode 5 split over two regs
      wr16(TCAP_ADDR_CNT_LO, 16'h00FF);
      chk({15'h0000, at_max}, 16'h0001);
      wr8(TCAP_ADDR_CTRL_B, 8'h09);
      wr8(TCAP_ADDR_CTRL_B, 8'h08); // Exactly one tick
      chk({count[14:0], at_zero}, 16'h0001);
      chk({15'h0000, ovf_irq}, 16'h0001);
      ovf_ack = 1'b1;
      idle(1);
      ovf_ack = 1'b0;
      chk({15'h0000, ovf_irq}, 16'h0000);
      wr8(TCAP_ADDR_CTRL_A, 8'h00);
      $display("count test done");
   endtask : t_run
   // Rising edge capture, acknowledge, ignored fall, overwrite
   task automatic t_capture();
      wr8(TCAP_ADDR_CTRL_B, 8'h40); // Rising edge selected
      wr8(TCAP_ADDR_IRQ_EN, 8'h20);
      wr16(TCAP_ADDR_CNT_LO, 16'h0321);
      i_src.drive(1'b1, 1'b0);
      wait_irq(lat_raw);
      idle(8);
      cap_ack = 1'b1;
      idle(1);
      cap_ack = 1'b0;
      chk({15'h0000, cap_irq}, 16'h0000);
      wr16(TCAP_ADDR_CNT_LO, 16'h0456);
      i_src.drive(1'b0, 1'b0);
      idle(10);
      chk({15'h0000, cap_irq}, 16'h0000);
      i_src.drive(1'b1, 1'b0);
      wait_irq(lat_raw);
      rd16(TCAP_ADDR_CAP_LO, rd_val);
      chk(rd_val, 16'h0456);
      wr8(TCAP_ADDR_FLAGS, 8'h20);
      idle(1);
      chk({15'h0000, cap_irq}, 16'h0000);
      $display("capture test done");
   endtask : t_capture
   // Filter rejects a short pulse and adds four cycles of delay
   task automatic t_filter();
      i_src.drive(1'b0, 1'b0);
      wr8(TCAP_ADDR_CTRL_B, 8'hC0);
      idle(10);
      wr8(TCAP_ADDR_FLAGS, 8'h20);
      i_src.drive(1'b1, 1'b0);
      idle(3); // Only three equal samples
      i_src.drive(1'b0, 1'b0);
      idle(10);
      chk({15'h0000, cap_irq}, 16'h0000);
      i_src.drive(1'b1, 1'b0);
      wait_irq(lat_flt);
      chk(16'(lat_flt), 16'(lat_raw + 4));
      $display("filter test done");
   endtask : t_filter
   // Comparator source, then capture-top mode with inputs off
   task automatic t_source();
      wr8(TCAP_ADDR_CTRL_B, 8'h40);
      wr8(TCAP_ADDR_CMP_CTRL, 8'h04);
      idle(10);
      wr8(TCAP_ADDR_FLAGS, 8'h20); // Drop any switch capture
      i_src.drive(1'b0, 1'b1); // Pin falls, comparator rises
      wait_irq(lat_raw);
      wr8(TCAP_ADDR_CTRL_B, 8'h18); // Mode 12 before the top value
      wr16(TCAP_ADDR_CAP_LO, 16'h0ABC);
      wr8(TCAP_ADDR_CNT_LO, 8'h12); // Latch reused
      chk(count, 16'h0A12);
      wr8(TCAP_ADDR_FLAGS, 8'h20);
      i_src.drive(1'b0, 1'b0);
      idle(10);
      chk({15'h0000, cap_irq}, 16'h0000);
      rd16(TCAP_ADDR_CAP_LO, rd_val);
      chk(rd_val, 16'h0ABC);
      $display("source test done");
   endtask : t_source
   // Reset for six cycles, then the scenarios in turn
   initial begin
      arst_n_i = 1'b0;
      cap_ack = 1'b0;
      ovf_ack = 1'b0;
      err_count = 0;
      checks_done = 0;
      idle(6);
      arst_n_i = 1'b1;
      idle(1);
      t_run();
      t_capture();
      t_filter();
      t_source();
      tally_and_finish();
   end
endmodule : tcap_timer_test
